/* src/scp_regs.vh */
// Constants for the serial control and data port.
// Assumes a single 40 MHz core clock; included by bare name.
`ifndef SCP_REGS_VH
`define SCP_REGS_VH
`define SCP_WORD_BITS       32
`define SCP_CTRL_BITS       4
`define SCP_ADDR_R0         4'h0
`define SCP_ADDR_SYNC       4'hb
`define SCP_ADDR_R15        4'hf
`define SCP_ADDR_READBACK   4'h7
`define SCP_UART_BIT_POS    28
`define SCP_SUBMODE_MSB     19
`define SCP_SUBMODE_LSB     17
`define SCP_SUBMODE_SPI     3'h7
`define SCP_SYNC_LSB        8
`define SCP_SYNC_BITS       24
`define SCP_RB_BITS         5'h10
`define SCP_RB_CNT_RESET    5'h00
`define SCP_CLK_PERIOD_NS   25
`define SCP_BIT_HALF_NS     100
`define SCP_BIT_HALF_CYC    ((`SCP_BIT_HALF_NS + `SCP_CLK_PERIOD_NS - 1) / `SCP_CLK_PERIOD_NS)
`define SCP_FIFO_DEPTH      4
`define SCP_FIFO_AW         2
`endif

/* src/scp_fifo.v */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; reset and flush clear it to empty.
module scp_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output reg              in_ready,
  output wire [WIDTH-1:0] out_data,
  output reg              out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  reg [AW:0]      count_next;
  wire            push;
  wire            pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rd_ptr_reg];

  // Occupancy after this cycle's push and pop
  always @*
  begin
    count_next = count_reg;
    if (push & ~pop)
      count_next = count_reg + 1'b1;
    else if (pop & ~push)
      count_next = count_reg - 1'b1;
  end

  // Flags are registered so the ready seen by the source is glitch free
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      in_ready   <= 1'b1;
      out_valid  <= 1'b0;
    end
    else if (flush)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      in_ready   <= 1'b1;
      out_valid  <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      in_ready  <= (count_next != DEPTH);
      out_valid <= (count_next != {(AW+1){1'b0}});
    end
  end

  // Storage has no reset; only written slots are ever read
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end
endmodule

/* src/scp_top.v */
// Serial programming port and data port of the transceiver core.
// Assumes host pins arrive asynchronous to CLK; demodulator and
// modulator signals are on CLK. One CLK, asynchronous RESET.
// Functional notes
// - Host presents bits; device shifts one bit per serial clock rise into 32 bits.
// - Load-enable rise copies the shift register into the selected latch.
// - During readback, one bit leaves on the readback pin per serial clock.
// - Chip enable low powers down and discards every programmed value.
// - Register 0 bit 28 set selects UART data-port mode.
// - SPI mode needs bit 28 set and register 15 bits 19..17 equal seven.
// - In UART/SPI mode the data clock leaves on the divided clock pin.
// - In four-level receive, symbol MSB/LSB phase is aligned at sync detect.
// - Sync-detect output asserts when received bits match the sync word.
// - UART/SPI: data pin drives receive data; in transmit, floats, clock pin inputs.
`include "scp_regs.vh"
module scp_top #(
  parameter BIT_HALF_CYC = `SCP_BIT_HALF_CYC,
  parameter FIFO_DEPTH   = `SCP_FIFO_DEPTH,
  parameter FIFO_AW      = `SCP_FIFO_AW
) (
  input  wire        CLK,
  input  wire        RESET,
  input  wire        CHIP_ENABLE,
  input  wire        PROG_SCLK,
  input  wire        PROG_SERIAL_IN,
  input  wire        PROG_LOAD_ENABLE,
  output reg         READBACK_OUT,
  input  wire [15:0] READBACK_WORD,
  output reg         LATCH_WRITE,
  output reg  [3:0]  LATCH_ADDR,
  output reg  [27:0] LATCH_DATA,
  output reg         POWERED_UP,
  output reg         UART_MODE,
  output reg         SPI_MODE,
  input  wire        TX_MODE,
  input  wire        FSK4_MODE,
  input  wire        RX_BIT,
  input  wire        RX_BIT_VALID,
  output wire        RX_BIT_READY,
  output reg         SYNC_DETECT,
  output reg         SYMBOL_MSB_PHASE,
  output reg         TX_BIT,
  output reg         TX_BIT_VALID,
  output reg         DIVIDED_REF_CLOCK_OUT,
  input  wire        DATA_BIT_CLOCK_IN,
  output reg         DATA_BIT_CLOCK_OUT,
  output reg         DATA_BIT_CLOCK_OE,
  input  wire        DATA_BIT_LINE_IN,
  output reg         DATA_BIT_LINE_OUT,
  output reg         DATA_BIT_LINE_OE
);
  // Pin synchronisers: stage 1 feeds only stage 2
  reg  [5:0]  sync1_reg;
  reg  [5:0]  sync2_reg;
  reg         sclk_d_reg;
  reg         sle_d_reg;
  wire        ce_s;
  wire        sclk_s;
  wire        prog_serial_in_s;
  wire        sle_s;
  wire        line_s;
  wire        sclk_rise;
  wire        sle_rise;
  // Serial programming state
  reg  [31:0] shift_reg;
  reg  [15:0] rb_shift_reg;
  reg  [4:0]  rb_count_reg;
  reg  [23:0] sync_word_reg;
  // Data port state
  reg  [7:0]  div_count_reg;
  reg  [23:0] rx_hist_reg;
  wire [23:0] rx_hist_next;
  wire        div_edge;
  wire        div_fall;
  wire        div_rise;
  wire        rx_accept;
  wire        fifo_out_data;
  wire        fifo_out_valid;
  wire        fifo_pop;
  wire        port_mode;
  wire        tx_pin_bit;
  wire [7:0]  half_last;

  // Divider terminal count, cut on purpose to the counter's eight bits
  localparam integer HALF_LAST_I = BIT_HALF_CYC - 1;

  // Bit picker shared by data path selection
  function pick_bit;
    input sel;
    input a;
    input b;
    begin
      pick_bit = sel ? a : b;
    end
  endfunction

  // Control-bit decode of the word waiting in the shift register
  function target_is;
    input [31:0] word;
    input [3:0]  addr;
    begin
      target_is = (word[`SCP_CTRL_BITS-1:0] == addr);
    end
  endfunction

  assign ce_s      = sync2_reg[0];
  assign sclk_s    = sync2_reg[1];
  assign prog_serial_in_s   = sync2_reg[2];
  assign sle_s     = sync2_reg[3];
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sle_rise  = sle_s & ~sle_d_reg;
  assign line_s    = sync2_reg[5];
  assign half_last = HALF_LAST_I[7:0];

  // Two flip-flops ahead of any logic for every asynchronous pin
  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      sync1_reg  <= 6'h00;
      sync2_reg  <= 6'h00;
      sclk_d_reg <= 1'b0;
      sle_d_reg  <= 1'b0;
    end
    else
    begin
      sync1_reg  <= {DATA_BIT_LINE_IN, DATA_BIT_CLOCK_IN, PROG_LOAD_ENABLE, PROG_SERIAL_IN,
                     PROG_SCLK, CHIP_ENABLE};
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sclk_s;
      sle_d_reg  <= sle_s;
    end
  end

  // Shift register, latch commit and readback; all cleared while powered down
  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      shift_reg     <= 32'h00000000;
      rb_shift_reg  <= 16'h0000;
      rb_count_reg  <= `SCP_RB_CNT_RESET;
      READBACK_OUT  <= 1'b0;
      LATCH_WRITE   <= 1'b0;
      LATCH_ADDR    <= 4'h0;
      LATCH_DATA    <= 28'h0000000;
      UART_MODE     <= 1'b0;
      SPI_MODE      <= 1'b0;
      sync_word_reg <= 24'h000000;
      POWERED_UP    <= 1'b0;
    end
    else if (!ce_s)
    begin
      shift_reg     <= 32'h00000000;
      rb_shift_reg  <= 16'h0000;
      rb_count_reg  <= `SCP_RB_CNT_RESET;
      READBACK_OUT  <= 1'b0;
      LATCH_WRITE   <= 1'b0;
      LATCH_ADDR    <= 4'h0;
      LATCH_DATA    <= 28'h0000000;
      UART_MODE     <= 1'b0;
      SPI_MODE      <= 1'b0;
      sync_word_reg <= 24'h000000;
      POWERED_UP    <= 1'b0;
    end
    else
    begin
      POWERED_UP  <= 1'b1;
      LATCH_WRITE <= 1'b0;
      // New bit enters at the bottom, so the first bit sent ends up on top
      if (sclk_rise)
        shift_reg <= {shift_reg[30:0], prog_serial_in_s};
      // Readback bit changes on each serial clock rise while bits remain
      if (sclk_rise && rb_count_reg != 5'h00)
      begin
        READBACK_OUT <= rb_shift_reg[15];
        rb_shift_reg <= {rb_shift_reg[14:0], 1'b0};
        rb_count_reg <= rb_count_reg - 5'h01;
      end
      // Latches move only here, so shifting alone never disturbs them
      if (sle_rise)
      begin
        LATCH_WRITE <= 1'b1;
        LATCH_ADDR  <= shift_reg[`SCP_CTRL_BITS-1:0];
        LATCH_DATA  <= shift_reg[`SCP_WORD_BITS-1:`SCP_CTRL_BITS];
        // Word decode; SPI needs the uart bit already committed
        if (target_is(shift_reg, `SCP_ADDR_R0))
        begin
          UART_MODE <= shift_reg[`SCP_UART_BIT_POS];
          if (!shift_reg[`SCP_UART_BIT_POS])
            SPI_MODE <= 1'b0;
        end
        if (target_is(shift_reg, `SCP_ADDR_R15))
          SPI_MODE <= UART_MODE &&
            (shift_reg[`SCP_SUBMODE_MSB:`SCP_SUBMODE_LSB] == `SCP_SUBMODE_SPI);
        // Sync word kept here; the receive matcher compares against it every bit
        if (target_is(shift_reg, `SCP_ADDR_SYNC))
          sync_word_reg <= shift_reg[`SCP_SYNC_LSB+`SCP_SYNC_BITS-1:`SCP_SYNC_LSB];
        // Readback word captured once; later changes wait for the next arming word
        if (target_is(shift_reg, `SCP_ADDR_READBACK))
        begin
          rb_shift_reg <= READBACK_WORD;
          rb_count_reg <= `SCP_RB_BITS;
        end
      end
    end
  end

  // Receive bits buffered so the pin pacing can stall the demodulator
  assign rx_accept = RX_BIT_VALID & RX_BIT_READY;
  assign port_mode = UART_MODE;

  // Flushed on power-down so no stale bit leaves after chip enable returns
  scp_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (CLK),
    .reset     (RESET),
    .flush     (~ce_s),
    .in_data   (RX_BIT),
    .in_valid  (RX_BIT_VALID),
    .in_ready  (RX_BIT_READY),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  // Bit clock divider; one data bit per full divided period
  assign div_edge = (div_count_reg == half_last);
  assign div_fall = div_edge & DIVIDED_REF_CLOCK_OUT;
  assign div_rise = div_edge & ~DIVIDED_REF_CLOCK_OUT;
  assign fifo_pop = div_fall & ~TX_MODE & fifo_out_valid;
  assign tx_pin_bit = pick_bit(port_mode, sync2_reg[4], line_s);
  assign rx_hist_next = {rx_hist_reg[22:0], RX_BIT};

  // Clock generation, pin direction and transmit sampling
  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      div_count_reg         <= 8'h00;
      DIVIDED_REF_CLOCK_OUT <= 1'b0;
      DATA_BIT_CLOCK_OUT    <= 1'b0;
      DATA_BIT_CLOCK_OE     <= 1'b0;
      DATA_BIT_LINE_OUT     <= 1'b0;
      DATA_BIT_LINE_OE      <= 1'b0;
      TX_BIT                <= 1'b0;
      TX_BIT_VALID          <= 1'b0;
    end
    else
    begin
      div_count_reg <= div_edge ? 8'h00 : div_count_reg + 8'h01;
      if (div_edge)
        DIVIDED_REF_CLOCK_OUT <= ~DIVIDED_REF_CLOCK_OUT;
      // Port mode moves the data clock to the divided clock pin
      DATA_BIT_CLOCK_OUT <= DIVIDED_REF_CLOCK_OUT;
      DATA_BIT_CLOCK_OE  <= ce_s & ~port_mode;
      // Data pin drives only while receiving; floats in transmit
      DATA_BIT_LINE_OE   <= ce_s & ~TX_MODE;
      if (fifo_pop)
        DATA_BIT_LINE_OUT <= fifo_out_data;
      // Transmit data taken on the bit clock rise from the right pin
      TX_BIT_VALID <= div_rise & TX_MODE & ce_s;
      if (div_rise)
        TX_BIT <= tx_pin_bit;
    end
  end

  // Sync word match and four-level symbol phase
  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      rx_hist_reg      <= 24'h000000;
      SYNC_DETECT      <= 1'b0;
      SYMBOL_MSB_PHASE <= 1'b1;
    end
    else if (!ce_s)
    begin
      rx_hist_reg      <= 24'h000000;
      SYNC_DETECT      <= 1'b0;
      SYMBOL_MSB_PHASE <= 1'b1;
    end
    else
    begin
      SYNC_DETECT <= 1'b0;
      if (rx_accept)
      begin
        rx_hist_reg <= rx_hist_next;
        if (rx_hist_next == sync_word_reg)
        begin
          SYNC_DETECT      <= 1'b1;
          SYMBOL_MSB_PHASE <= 1'b1;
        end
        else if (FSK4_MODE)
          SYMBOL_MSB_PHASE <= ~SYMBOL_MSB_PHASE;
        else
          SYMBOL_MSB_PHASE <= 1'b1;
      end
    end
  end
endmodule

/* dv/scp_top_assertions.sv */
// Concurrent checks on the serial port top, seen through its ports only.
// Assumes one core clock and an asynchronous active-high reset.
module scp_top_assertions #(
  parameter BIT_HALF_CYC = 4
) (
  input wire        CLK,
  input wire        RESET,
  input wire        CHIP_ENABLE,
  input wire        PROG_LOAD_ENABLE,
  input wire        LATCH_WRITE,
  input wire [3:0]  LATCH_ADDR,
  input wire [27:0] LATCH_DATA,
  input wire        POWERED_UP,
  input wire        UART_MODE,
  input wire        SPI_MODE,
  input wire        TX_MODE,
  input wire        FSK4_MODE,
  input wire        RX_BIT_VALID,
  input wire        RX_BIT_READY,
  input wire        SYNC_DETECT,
  input wire        SYMBOL_MSB_PHASE,
  input wire        DIVIDED_REF_CLOCK_OUT,
  input wire        DATA_BIT_CLOCK_OE,
  input wire        DATA_BIT_LINE_OE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (RESET);

  // Cycles since the divided clock toggled; a phase cut by power-down is skipped
  logic [7:0] half_cnt_reg;
  logic       div_q_reg;
  logic       seen_reg;
  wire        div_edge = DIVIDED_REF_CLOCK_OUT != div_q_reg;
  always_ff @(posedge CLK or posedge RESET)
    if (RESET)
    begin
      half_cnt_reg <= 8'h00;
      div_q_reg    <= 1'b0;
      seen_reg     <= 1'b0;
    end
    else
    begin
      half_cnt_reg <= div_edge ? 8'h01 : half_cnt_reg + 8'h01;
      div_q_reg    <= DIVIDED_REF_CLOCK_OUT;
      seen_reg     <= CHIP_ENABLE && (seen_reg || div_edge);
    end

  // Commit steps: load pin rise, then a write pulse naming the target
  sequence s_load_rise;
    $rose(PROG_LOAD_ENABLE);
  endsequence
  sequence s_reg0_commit;
    LATCH_WRITE && LATCH_ADDR == 4'h0;
  endsequence

  a_load_commits: assert property (s_load_rise |-> ##[2:5] LATCH_WRITE)
    else $error("load rise gave no write");
  a_write_single: assert property (LATCH_WRITE |=> !LATCH_WRITE)
    else $error("write pulse too long");
  a_no_stray_write: assert property (!PROG_LOAD_ENABLE [*6] |-> !LATCH_WRITE)
    else $error("write without load rise");
  a_uart_from_bit: assert property (
    s_reg0_commit |=> UART_MODE == $past(LATCH_DATA[24]))
    else $error("uart mode not from bit 28");
  a_spi_needs_uart: assert property (SPI_MODE |-> UART_MODE)
    else $error("spi mode without uart bit");
  a_power_clears: assert property (
    !CHIP_ENABLE [*5] |-> !POWERED_UP && !UART_MODE && !SPI_MODE)
    else $error("state kept with chip off");
  a_sync_cause: assert property (
    SYNC_DETECT |-> $past(RX_BIT_VALID) && $past(RX_BIT_READY))
    else $error("sync without accepted bit");
  a_sync_phase: assert property (SYNC_DETECT && FSK4_MODE |-> SYMBOL_MSB_PHASE)
    else $error("symbol phase not aligned");
  a_clk_pin_free: assert property (UART_MODE && $stable(UART_MODE) |-> !DATA_BIT_CLOCK_OE)
    else $error("clock pin driven in uart");
  a_line_floats: assert property (
    TX_MODE && $stable(TX_MODE) && UART_MODE |-> !DATA_BIT_LINE_OE)
    else $error("data pin driven in transmit");
  a_ref_half: assert property (div_edge && seen_reg |-> half_cnt_reg == BIT_HALF_CYC)
    else $error("divided clock half period wrong");
endmodule

bind scp_top scp_top_assertions #(.BIT_HALF_CYC(BIT_HALF_CYC)) scp_top_assertions_inst (
  .CLK                   (CLK),
  .RESET                 (RESET),
  .CHIP_ENABLE           (CHIP_ENABLE),
  .PROG_LOAD_ENABLE      (PROG_LOAD_ENABLE),
  .LATCH_WRITE           (LATCH_WRITE),
  .LATCH_ADDR            (LATCH_ADDR),
  .LATCH_DATA            (LATCH_DATA),
  .POWERED_UP            (POWERED_UP),
  .UART_MODE             (UART_MODE),
  .SPI_MODE              (SPI_MODE),
  .TX_MODE               (TX_MODE),
  .FSK4_MODE             (FSK4_MODE),
  .RX_BIT_VALID          (RX_BIT_VALID),
  .RX_BIT_READY          (RX_BIT_READY),
  .SYNC_DETECT           (SYNC_DETECT),
  .SYMBOL_MSB_PHASE      (SYMBOL_MSB_PHASE),
  .DIVIDED_REF_CLOCK_OUT (DIVIDED_REF_CLOCK_OUT),
  .DATA_BIT_CLOCK_OE     (DATA_BIT_CLOCK_OE),
  .DATA_BIT_LINE_OE      (DATA_BIT_LINE_OE)
);

/* dv/scp_host_model.sv */
// Host model: drives the three programming pins and reads back bits.
// Assumes the core clock; pins move only on its falling edges.
module scp_host_model (
  input  wire  CLK,
  input  wire  READBACK_OUT,
  input  wire  DATA_BIT_CLOCK_OUT,
  output logic PROG_SCLK,
  output logic PROG_SERIAL_IN,
  output logic PROG_LOAD_ENABLE
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    PROG_SCLK = 1'b0;
    PROG_SERIAL_IN = 1'b0;
    PROG_LOAD_ENABLE = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge CLK);
  endtask
  // Word MSB first; 4 cycles per level keeps pins steady past the pin sync
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      PROG_SERIAL_IN = w[i];
      idle(4);
      PROG_SCLK = 1'b1;
      idle(4);
      PROG_SCLK = 1'b0;
      idle(4);
    end
    PROG_SERIAL_IN = ~w[0]; // Released line shows no stale bit
    // Load half a core cycle after a data clock fall, far from the next rise
    @(negedge DATA_BIT_CLOCK_OUT);
    @(negedge CLK);
    PROG_LOAD_ENABLE = 1'b1;
    idle(4);
    PROG_LOAD_ENABLE = 1'b0;
    idle(4);
  endtask
  // Each rise brings the next bit; taken just before the fall
  task automatic read_back(output logic [15:0] v);
    for (int i = 0; i < 16; i++)
    begin
      PROG_SCLK = 1'b1;
      idle(6);
      v = {v[14:0], READBACK_OUT};
      PROG_SCLK = 1'b0;
      idle(4);
    end
  endtask
endmodule

/* dv/scp_top_tb.sv */
// Self-checking bench for the serial programming and data port.
// Assumes the host model drives the programming pins.
module scp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CLK = 1'b0, RESET = 1'b1, CHIP_ENABLE = 1'b1, TX_MODE = 1'b0;
  logic        FSK4_MODE = 1'b0, RX_BIT = 1'b0, RX_BIT_VALID = 1'b0;
  logic [15:0] READBACK_WORD = 16'h0000;
  logic        PROG_SCLK, PROG_SERIAL_IN, PROG_LOAD_ENABLE, READBACK_OUT, LATCH_WRITE;
  logic        POWERED_UP, UART_MODE, SPI_MODE, RX_BIT_READY, SYNC_DETECT;
  logic        SYMBOL_MSB_PHASE, TX_BIT, TX_BIT_VALID, DIVIDED_REF_CLOCK_OUT;
  logic        DATA_BIT_CLOCK_OUT, DATA_BIT_CLOCK_OE, DATA_BIT_LINE_OUT, DATA_BIT_LINE_OE;
  logic [3:0]  LATCH_ADDR;
  logic [27:0] LATCH_DATA;
  logic [31:0] last_wr;
  logic        phase_at_sync;
  wire         DATA_BIT_CLOCK_IN, DATA_BIT_LINE_IN;
  int          miscompares = 0, check_count = 0, wr_cnt = 0, sync_cnt = 0, full_seen = 0;
  int          tx_cnt = 0, line_ones = 0;
  logic        div_prev = 1'b0;

  always #12.5 CLK = ~CLK;
  // Pin levels resolved from both parties; the far side pulls idle lines apart
  assign DATA_BIT_CLOCK_IN = DATA_BIT_CLOCK_OE ? DATA_BIT_CLOCK_OUT : 1'b1;
  assign DATA_BIT_LINE_IN  = DATA_BIT_LINE_OE ? DATA_BIT_LINE_OUT : 1'b0;

  scp_top scp_top_inst (
    .CLK                   (CLK),
    .RESET                 (RESET),
    .CHIP_ENABLE           (CHIP_ENABLE),
    .PROG_SCLK             (PROG_SCLK),
    .PROG_SERIAL_IN        (PROG_SERIAL_IN),
    .PROG_LOAD_ENABLE      (PROG_LOAD_ENABLE),
    .READBACK_OUT          (READBACK_OUT),
    .READBACK_WORD         (READBACK_WORD),
    .LATCH_WRITE           (LATCH_WRITE),
    .LATCH_ADDR            (LATCH_ADDR),
    .LATCH_DATA            (LATCH_DATA),
    .POWERED_UP            (POWERED_UP),
    .UART_MODE             (UART_MODE),
    .SPI_MODE              (SPI_MODE),
    .TX_MODE               (TX_MODE),
    .FSK4_MODE             (FSK4_MODE),
    .RX_BIT                (RX_BIT),
    .RX_BIT_VALID          (RX_BIT_VALID),
    .RX_BIT_READY          (RX_BIT_READY),
    .SYNC_DETECT           (SYNC_DETECT),
    .SYMBOL_MSB_PHASE      (SYMBOL_MSB_PHASE),
    .TX_BIT                (TX_BIT),
    .TX_BIT_VALID          (TX_BIT_VALID),
    .DIVIDED_REF_CLOCK_OUT (DIVIDED_REF_CLOCK_OUT),
    .DATA_BIT_CLOCK_IN     (DATA_BIT_CLOCK_IN),
    .DATA_BIT_CLOCK_OUT    (DATA_BIT_CLOCK_OUT),
    .DATA_BIT_CLOCK_OE     (DATA_BIT_CLOCK_OE),
    .DATA_BIT_LINE_IN      (DATA_BIT_LINE_IN),
    .DATA_BIT_LINE_OUT     (DATA_BIT_LINE_OUT),
    .DATA_BIT_LINE_OE      (DATA_BIT_LINE_OE)
  );
  scp_host_model scp_host_model_inst (
    .CLK                (CLK),
    .READBACK_OUT       (READBACK_OUT),
    .DATA_BIT_CLOCK_OUT (DATA_BIT_CLOCK_OUT),
    .PROG_SCLK          (PROG_SCLK),
    .PROG_SERIAL_IN     (PROG_SERIAL_IN),
    .PROG_LOAD_ENABLE   (PROG_LOAD_ENABLE)
  );

  // Event monitor: counts pulses mid-cycle so a doubled or missing one shows
  always @(negedge CLK)
  begin
    if (LATCH_WRITE === 1'b1)
    begin
      wr_cnt++;
      last_wr = {LATCH_DATA, LATCH_ADDR};
    end
    if (SYNC_DETECT === 1'b1)
    begin
      sync_cnt++;
      phase_at_sync = SYMBOL_MSB_PHASE;
    end
    if (RX_BIT_READY === 1'b0)
      full_seen++;
    if (TX_BIT_VALID === 1'b1)
      tx_cnt++;
    // One sample per data bit, taken at the divided clock rise mid-bit
    if (DIVIDED_REF_CLOCK_OUT === 1'b1 && div_prev === 1'b0 && DATA_BIT_LINE_OUT === 1'b1)
      line_ones++;
    div_prev = DIVIDED_REF_CLOCK_OUT;
  end

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [31:0] w);
    scp_host_model_inst.send_word(w);
  endtask
  task automatic final_report();
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Every target address once; exactly one write each, nothing before load
  task automatic t_latch();
    logic [31:0] w;
    int          n;
    for (int i = 0; i < 16; i++)
    begin
      w = {24'h0a5c3e, i[3:0], i[3:0]};
      n = wr_cnt;
      wr(w);
      chk(wr_cnt === n + 1 && last_wr === w, "latched word");
    end
  endtask
  // Mode bits, including the field set while the uart bit is clear
  task automatic t_modes();
    int n;
    wr(32'h1000_0000);
    chk(UART_MODE === 1'b1 && SPI_MODE === 1'b0, "uart mode");
    chk(DATA_BIT_CLOCK_OE === 1'b0, "clock pin driven");
    TX_MODE = 1'b1;
    n = tx_cnt;
    scp_host_model_inst.idle(8);
    chk(DATA_BIT_LINE_OE === 1'b0, "data pin driven in tx");
    chk(TX_BIT === 1'b1, "tx bit not from clock pin");
    TX_MODE = 1'b0;
    scp_host_model_inst.idle(1);
    chk(tx_cnt === n + 1, "tx bit pulses per bit period");
    wr(32'h000e_000f);
    chk(SPI_MODE === 1'b1 && DATA_BIT_LINE_OE === 1'b1, "spi mode");
    wr(32'h0000_0000);
    wr(32'h000e_000f);
    chk(UART_MODE === 1'b0 && SPI_MODE === 1'b0, "spi without uart");
  endtask
  task automatic t_readback();
    logic [15:0] v;
    READBACK_WORD = 16'hb38d;
    wr(32'h0000_0007);
    scp_host_model_inst.read_back(v);
    chk(v === 16'hb38d, "readback bits");
  endtask
  // Sync word fed back to back, so the buffer fills while draining slowly
  task automatic t_sync();
    logic [27:0] s;
    int          n;
    s = {4'hf, 24'h9d2b6c};
    wr({24'h9d2b6c, 8'h0b});
    FSK4_MODE = 1'b1;
    n = sync_cnt;
    for (int i = 27; i >= 0; i--)
    begin
      RX_BIT = s[i];
      RX_BIT_VALID = 1'b1;
      while (RX_BIT_READY !== 1'b1)
        @(negedge CLK);
      @(negedge CLK);
    end
    RX_BIT_VALID = 1'b0;
    scp_host_model_inst.idle(48);
    chk(sync_cnt === n + 1 && phase_at_sync === 1'b1, "sync pulse");
    chk(full_seen > 0 && RX_BIT_READY === 1'b1, "rx buffer");
    chk(line_ones === $countones(s), "received bits on data pin");
  endtask
  task automatic t_power();
    wr(32'h1000_0000);
    CHIP_ENABLE = 1'b0;
    scp_host_model_inst.idle(8);
    chk(POWERED_UP === 1'b0 && UART_MODE === 1'b0, "powered down");
    CHIP_ENABLE = 1'b1;
    scp_host_model_inst.idle(8);
    chk(POWERED_UP === 1'b1 && UART_MODE === 1'b0, "settings lost");
    wr(32'h1000_0000);
    chk(UART_MODE === 1'b1, "rewritten");
  endtask

  initial
  begin
    repeat (6) @(negedge CLK);
    RESET = 1'b0;
    scp_host_model_inst.idle(6);
    t_latch();
    t_modes();
    t_readback();
    t_sync();
    t_power();
    final_report();
  end
  // Watchdog: the whole sequence needs about 10000 cycles
  initial
  begin
    repeat (40000) @(posedge CLK);
    miscompares++;
    final_report();
  end
endmodule
